// >>> swire_pkg.sv
// Constants, types and state record for the single-wire slave command port
package swire_pkg;

  // Clock and bit-level timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_LOW_TIME_NS = 120000;
  localparam int WRITE_SAMPLE_MIN_NS = 15000;
  localparam int WRITE_SAMPLE_MAX_NS = 60000;
  localparam int READ_VALID_TIME_NS = 15000;
  localparam int READ_HOLD_NS = 2 * READ_VALID_TIME_NS;
  localparam int PRESENCE_WAIT_TIME_NS = 30000;
  localparam int PRESENCE_LOW_TIME_NS = 120000;
  localparam int EEPROM_COPY_TIME_NS = 2000000;

  localparam logic [15:0] RESET_CYC = 16'((RESET_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] SAMPLE_CYC = 16'(((WRITE_SAMPLE_MIN_NS + WRITE_SAMPLE_MAX_NS) / 2) / CLK_PERIOD_NS);
  localparam logic [15:0] READ_HOLD_CYC = 16'(READ_HOLD_NS / CLK_PERIOD_NS);
  localparam logic [15:0] PRES_WAIT_CYC = 16'((PRESENCE_WAIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PRES_LOW_CYC = 16'((PRESENCE_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int COPY_CYC = EEPROM_COPY_TIME_NS / CLK_PERIOD_NS;

  // Net-address and function opcodes
  localparam logic [7:0] OP_READ_NET_0 = 8'h33;
  localparam logic [7:0] OP_READ_NET_1 = 8'h39;
  localparam logic [7:0] OP_MATCH_NET = 8'h55;
  localparam logic [7:0] OP_SKIP_NET = 8'hCC;
  localparam logic [7:0] OP_SEARCH_NET = 8'hF0;
  localparam logic [7:0] OP_SWAP = 8'hAA;
  localparam logic [7:0] OP_READ_DATA = 8'h69;
  localparam logic [7:0] OP_WRITE_DATA = 8'h6C;
  localparam logic [7:0] OP_COPY = 8'h48;
  localparam logic [7:0] OP_RECALL = 8'hB8;
  localparam logic [7:0] OP_LOCK = 8'h6A;

  // Device memory map
  localparam logic [7:0] MEM_STATUS = 8'h01;
  localparam logic [7:0] MEM_EEREG = 8'h07;
  localparam logic [7:0] MEM_SPECIAL = 8'h08;
  localparam logic [7:0] MEM_EE_BASE = 8'h20;
  localparam logic [7:0] MEM_EE_TOP = 8'h3F;
  localparam logic [7:0] MEM_SRAM_BASE = 8'h80;
  localparam logic [7:0] MEM_SRAM_TOP = 8'h8F;
  localparam logic [7:0] MEM_TOP = 8'hFF;
  localparam int STATUS_OPSEL_BIT = 4;
  localparam int STATUS_SWAP_RECOGNITION_ENABLE_BIT = 3;
  localparam int EEREG_BUSY_BIT = 7;
  localparam int EEREG_LOCKEN_BIT = 6;
  localparam int SPECIAL_MASTER_BIT = 5;

  // APB register offsets and fields
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_NET_LO = 12'h008;
  localparam logic [11:0] APB_NET_HI = 12'h00C;
  localparam int CTRL_OPSEL_BIT = 0;
  localparam int CTRL_SWAP_RECOGNITION_ENABLE_BIT = 1;

  // Net address after reset; value is arbitrary
  localparam logic [63:0] NET_ADDR_RESET = 64'h5A00_0000_0000_0001;

  typedef enum logic [3:0] {
    P_IDLE = 4'b0000,
    P_NETCMD = 4'b0001,
    P_RDNET = 4'b0010,
    P_MATCH = 4'b0011,
    P_SEARCH = 4'b0100,
    P_SWAPADDR = 4'b0101,
    P_SWAPPULSE = 4'b0110,
    P_FUNC = 4'b0111,
    P_ADDR = 4'b1000,
    P_READ = 4'b1001,
    P_WRITE = 4'b1010,
    P_WAITRST = 4'b1011
  } proto_e;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [15:0] low_cnt;
    logic [15:0] slot_cnt;
    logic [15:0] pres_cnt;
    logic [15:0] copy_cnt;
    logic slot_act;
    logic pend0;
    logic rst_seen;
    logic [1:0] pres_ph;
    logic dq_oe;
    proto_e st;
    logic [6:0] bcnt;
    logic [1:0] step;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic hit;
    logic [7:0] addr;
    logic ovf;
    logic opsel;
    logic swap_recognition_enable;
    logic lock_en;
    logic copy_busy;
    logic copy_blk;
    logic [1:0] locked;
    logic master;
    logic chg;
    logic dis;
    logic [63:0] netaddr;
    logic [31:0][7:0] shadow;
    logic [31:0][7:0] eeprom;
    logic [15:0][7:0] sram;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_s;

endpackage

// >>> swire_slave.sv
// Single-wire slave command port with APB configuration and status
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps

//
// Operation
// - Read net address on selectable opcode
// - Match address; others wait for reset
// - Skip address goes straight to function
// - Search sends bit, complement, reads choice
// - Swap recognised only when swap enabled
// - Pulse fall cuts power, rise selects
// - Read data LSB first, address increments
// - Past top address read returns ones
// - Reset at bit boundary abandons read
// - Write data LSB first, drop beyond top
// - Drop writes to protected locations
// - Partial bytes dropped; writes go shadow
// - Copy shadow block unless block locked
// - Copy busy flag; blocks EEPROM writes
// - Recall reloads shadow from EEPROM block
// - Lock block only when lock enabled
// - Up to 256 bytes; else idle
// - Presence pulse after wait from rise
// - Sample write slot between 15-60us
// - Device drives read bit, releases before end
// - Low beyond 120us is reset
// - Lock clears the lock enable bit
// - Two EEPROM blocks with lock flags
module swire_slave #(
  parameter int unsigned COPY_CYC = swire_pkg::COPY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe,
  output logic charge_switch_output,
  output logic discharge_switch_output,
  output logic eeprom_copy_busy_flag,
  output logic block0_locked_flag,
  output logic block1_locked_flag
);

  swire_pkg::state_s r;
  swire_pkg::state_s n;

  function automatic logic in_ee(input logic [7:0] a);
    in_ee = (a >= swire_pkg::MEM_EE_BASE) && (a <= swire_pkg::MEM_EE_TOP);
  endfunction

  function automatic logic in_sram(input logic [7:0] a);
    in_sram = (a >= swire_pkg::MEM_SRAM_BASE) && (a <= swire_pkg::MEM_SRAM_TOP);
  endfunction

  // Reserved locations read as zero
  function automatic logic [7:0] mem_read(input swire_pkg::state_s s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == swire_pkg::MEM_STATUS)
    begin
      d[swire_pkg::STATUS_OPSEL_BIT] = s.opsel;
      d[swire_pkg::STATUS_SWAP_RECOGNITION_ENABLE_BIT] = s.swap_recognition_enable;
    end
    else if (a == swire_pkg::MEM_EEREG)
      d = {s.copy_busy, s.lock_en, 4'h0, s.locked};
    else if (a == swire_pkg::MEM_SPECIAL)
      d[swire_pkg::SPECIAL_MASTER_BIT] = s.master;
    else if (in_ee(a))
      d = s.shadow[a[4:0]];
    else if (in_sram(a))
      d = s.sram[a[3:0]];
    mem_read = d;
  endfunction

  always_comb
  begin
    logic fall;
    logic rise;
    logic tx;
    logic txb;
    logic bit_ev;
    logic bit_val;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic apb_acc;
    fall = 1'b0;
    rise = 1'b0;
    tx = 1'b0;
    txb = 1'b1;
    bit_ev = 1'b0;
    bit_val = 1'b0;
    byte_in = 8'h00;
    rd_byte = 8'h00;
    apb_acc = 1'b0;
    n = r;

    // Edges come from the second and third stages; the first is not looked at
    n.s1 = dq_in;
    n.s2 = r.s1;
    n.s3 = r.s2;
    fall = r.s3 & ~r.s2;
    rise = ~r.s3 & r.s2;
    rd_byte = mem_read(r, r.addr);

    case (r.st)
      swire_pkg::P_RDNET:
      begin
        tx = 1'b1;
        txb = r.netaddr[r.bcnt[5:0]];
      end
      swire_pkg::P_SEARCH:
      begin
        if (r.step != 2'd2)
        begin
          tx = 1'b1;
          txb = r.netaddr[r.bcnt[5:0]] ^ r.step[0];
        end
      end
      swire_pkg::P_READ:
      begin
        tx = 1'b1;
        txb = r.ovf | rd_byte[r.bcnt[2:0]];
      end
      default:
      begin
        tx = 1'b0;
      end
    endcase

    if (r.s2)
      n.low_cnt = 16'h0000;
    else if (r.low_cnt != 16'hFFFF)
      n.low_cnt = r.low_cnt + 16'h0001;
    if (!r.s2 && (r.low_cnt >= swire_pkg::RESET_CYC))
      n.rst_seen = 1'b1;

    // Presence pulse owns the line; slot decoding paused meanwhile
    if (r.pres_ph != 2'd0)
    begin
      n.pres_cnt = r.pres_cnt + 16'h0001;
      if (r.pres_ph == 2'd1 && r.pres_cnt == swire_pkg::PRES_WAIT_CYC - 16'h0001)
      begin
        n.pres_ph = 2'd2;
        n.pres_cnt = 16'h0000;
        n.dq_oe = 1'b1;
      end
      else if (r.pres_ph == 2'd2 && r.pres_cnt == swire_pkg::PRES_LOW_CYC - 16'h0001)
      begin
        n.pres_ph = 2'd0;
        n.dq_oe = 1'b0;
      end
    end
    else if (r.rst_seen && rise)
    begin
      n.rst_seen = 1'b0;
      n.pres_ph = 2'd1;
      n.pres_cnt = 16'h0000;
      n.st = swire_pkg::P_NETCMD;
      n.bcnt = 7'd0;
      n.step = 2'd0;
      n.slot_act = 1'b0;
      n.pend0 = 1'b0;
      n.dq_oe = 1'b0;
    end
    else if (r.rst_seen || n.rst_seen)
    begin
      // A long low never completes a received bit; in a transmit state the bit already counted at the sample point
      n.slot_act = 1'b0;
      n.pend0 = 1'b0;
      n.dq_oe = 1'b0;
    end
    else if (r.st == swire_pkg::P_SWAPPULSE)
    begin
      if (fall)
      begin
        n.chg = 1'b0;
        n.dis = 1'b0;
        n.step = 2'd1;
      end
      else if (rise && r.step == 2'd1)
      begin
        n.chg = r.hit;
        n.dis = r.hit;
        n.master = r.hit;
        n.st = swire_pkg::P_WAITRST;
      end
    end
    else if (fall)
    begin
      n.slot_act = 1'b1;
      n.slot_cnt = 16'h0000;
      n.pend0 = 1'b0;
      n.dq_oe = tx & ~txb;
    end
    else if (r.slot_act)
    begin
      n.slot_cnt = r.slot_cnt + 16'h0001;
      if (r.slot_cnt == swire_pkg::READ_HOLD_CYC)
        n.dq_oe = 1'b0;
      if (r.slot_cnt == swire_pkg::SAMPLE_CYC)
      begin
        n.slot_act = 1'b0;
        // Low write sample held until the rise, so a reset is not taken as a 0
        if (tx || r.s2)
        begin
          bit_ev = 1'b1;
          bit_val = r.s2;
        end
        else
          n.pend0 = 1'b1;
      end
    end
    else if (r.pend0 && rise)
    begin
      n.pend0 = 1'b0;
      bit_ev = 1'b1;
      bit_val = 1'b0;
    end

    if (bit_ev)
    begin
      byte_in = {bit_val, r.sh[7:1]};
      n.sh = byte_in;
      n.bcnt = r.bcnt + 7'd1;
      case (r.st)
        swire_pkg::P_NETCMD:
        begin
          if (r.bcnt == 7'd7)
          begin
            n.bcnt = 7'd0;
            n.hit = 1'b1;
            n.step = 2'd0;
            n.st = swire_pkg::P_WAITRST;
            if (byte_in == (r.opsel ? swire_pkg::OP_READ_NET_1 : swire_pkg::OP_READ_NET_0))
              n.st = swire_pkg::P_RDNET;
            else if (byte_in == swire_pkg::OP_MATCH_NET)
              n.st = swire_pkg::P_MATCH;
            else if (byte_in == swire_pkg::OP_SKIP_NET)
              n.st = swire_pkg::P_FUNC;
            else if (byte_in == swire_pkg::OP_SEARCH_NET)
              n.st = swire_pkg::P_SEARCH;
            else if (byte_in == swire_pkg::OP_SWAP && r.swap_recognition_enable)
              n.st = swire_pkg::P_SWAPADDR;
          end
        end
        swire_pkg::P_RDNET:
        begin
          if (r.bcnt == 7'd63)
          begin
            n.bcnt = 7'd0;
            n.st = swire_pkg::P_FUNC;
          end
        end
        swire_pkg::P_MATCH, swire_pkg::P_SWAPADDR:
        begin
          if (bit_val != r.netaddr[r.bcnt[5:0]])
            n.hit = 1'b0;
          if (r.bcnt == 7'd63)
          begin
            n.bcnt = 7'd0;
            n.step = 2'd0;
            if (r.st == swire_pkg::P_SWAPADDR)
              n.st = swire_pkg::P_SWAPPULSE;
            else
              n.st = n.hit ? swire_pkg::P_FUNC : swire_pkg::P_WAITRST;
          end
        end
        swire_pkg::P_SEARCH:
        begin
          n.bcnt = r.bcnt;
          n.step = r.step + 2'd1;
          if (r.step == 2'd2)
          begin
            n.step = 2'd0;
            n.bcnt = r.bcnt + 7'd1;
            if (bit_val != r.netaddr[r.bcnt[5:0]])
              n.st = swire_pkg::P_WAITRST;
            else if (r.bcnt == 7'd63)
            begin
              n.bcnt = 7'd0;
              n.st = swire_pkg::P_FUNC;
            end
          end
        end
        swire_pkg::P_FUNC:
        begin
          if (r.bcnt == 7'd7)
          begin
            n.bcnt = 7'd0;
            n.cmd = byte_in;
            if (byte_in == swire_pkg::OP_READ_DATA || byte_in == swire_pkg::OP_WRITE_DATA ||
                byte_in == swire_pkg::OP_COPY || byte_in == swire_pkg::OP_RECALL ||
                byte_in == swire_pkg::OP_LOCK)
              n.st = swire_pkg::P_ADDR;
            else
              n.st = swire_pkg::P_WAITRST;
          end
        end
        swire_pkg::P_ADDR:
        begin
          if (r.bcnt == 7'd7)
          begin
            n.bcnt = 7'd0;
            n.addr = byte_in;
            n.ovf = 1'b0;
            n.st = swire_pkg::P_WAITRST;
            if (r.cmd == swire_pkg::OP_READ_DATA)
              n.st = swire_pkg::P_READ;
            else if (r.cmd == swire_pkg::OP_WRITE_DATA)
              n.st = swire_pkg::P_WRITE;
            else if (in_ee(byte_in))
            begin
              if (r.cmd == swire_pkg::OP_COPY && !r.locked[byte_in[4]] && !r.copy_busy)
              begin
                n.copy_busy = 1'b1;
                n.copy_cnt = 16'h0000;
                n.copy_blk = byte_in[4];
              end
              else if (r.cmd == swire_pkg::OP_RECALL && !r.copy_busy)
              begin
                for (int i = 0; i < 16; i++)
                  n.shadow[{byte_in[4], 4'(i)}] = r.eeprom[{byte_in[4], 4'(i)}];
              end
              else if (r.cmd == swire_pkg::OP_LOCK && r.lock_en)
              begin
                n.locked[byte_in[4]] = 1'b1;
                n.lock_en = 1'b0;
              end
            end
          end
        end
        swire_pkg::P_READ:
        begin
          if (r.bcnt[2:0] == 3'd7)
          begin
            n.bcnt = 7'd0;
            n.addr = r.addr + 8'h01;
            if (r.addr == swire_pkg::MEM_TOP)
              n.ovf = 1'b1;
          end
        end
        swire_pkg::P_WRITE:
        begin
          if (r.bcnt[2:0] == 3'd7)
          begin
            n.bcnt = 7'd0;
            n.addr = r.addr + 8'h01;
            if (r.addr == swire_pkg::MEM_TOP)
              n.ovf = 1'b1;
            // Only whole bytes reach storage
            if (!r.ovf)
            begin
              if (in_ee(r.addr) && !r.locked[r.addr[4]] && !r.copy_busy)
                n.shadow[r.addr[4:0]] = byte_in;
              else if (in_sram(r.addr))
                n.sram[r.addr[3:0]] = byte_in;
              else if (r.addr == swire_pkg::MEM_EEREG)
                n.lock_en = byte_in[swire_pkg::EEREG_LOCKEN_BIT];
            end
          end
        end
        default:
        begin
          n.bcnt = 7'd0;
        end
      endcase
    end

    // Copy runs in the background; non-EEPROM accesses carry on
    if (r.copy_busy)
    begin
      n.copy_cnt = r.copy_cnt + 16'h0001;
      if (r.copy_cnt == 16'(COPY_CYC - 1))
      begin
        n.copy_busy = 1'b0;
        for (int i = 0; i < 16; i++)
          n.eeprom[{r.copy_blk, 4'(i)}] = r.shadow[{r.copy_blk, 4'(i)}];
      end
    end

    // APB slave: one wait state, write lands on the completing edge
    apb_acc = psel & penable;
    n.pready = apb_acc & ~r.pready;
    if (apb_acc && !r.pready)
    begin
      n.pslverr = 1'b0;
      n.prdata = 32'h0000_0000;
      case (paddr)
        swire_pkg::APB_CTRL:
        begin
          n.prdata[swire_pkg::CTRL_OPSEL_BIT] = r.opsel;
          n.prdata[swire_pkg::CTRL_SWAP_RECOGNITION_ENABLE_BIT] = r.swap_recognition_enable;
        end
        swire_pkg::APB_STATUS:
          n.prdata = {24'h000000, r.master, r.chg, r.dis, r.copy_busy, r.lock_en, r.locked[1], r.locked[0],
            r.st == swire_pkg::P_IDLE};
        swire_pkg::APB_NET_LO:
          n.prdata = r.netaddr[31:0];
        swire_pkg::APB_NET_HI:
          n.prdata = r.netaddr[63:32];
        default:
          n.pslverr = 1'b1;
      endcase
    end
    if (apb_acc && r.pready && pwrite && !r.pslverr)
    begin
      case (paddr)
        swire_pkg::APB_CTRL:
        begin
          n.opsel = pwdata[swire_pkg::CTRL_OPSEL_BIT];
          n.swap_recognition_enable = pwdata[swire_pkg::CTRL_SWAP_RECOGNITION_ENABLE_BIT];
        end
        swire_pkg::APB_NET_LO:
          n.netaddr[31:0] = pwdata;
        swire_pkg::APB_NET_HI:
          n.netaddr[63:32] = pwdata;
        default:
        begin
          n.pslverr = r.pslverr;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.s1 <= 1'b1;
      r.s2 <= 1'b1;
      r.s3 <= 1'b1;
      r.chg <= 1'b1;
      r.dis <= 1'b1;
      r.netaddr <= swire_pkg::NET_ADDR_RESET;
    end
    else
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  // Open drain: only ever pulls low
  assign dq_out = 1'b0;
  assign dq_oe = r.dq_oe;
  assign charge_switch_output = r.chg;
  assign discharge_switch_output = r.dis;
  assign eeprom_copy_busy_flag = r.copy_busy;
  assign block0_locked_flag = r.locked[0];
  assign block1_locked_flag = r.locked[1];

endmodule // swire_slave

// >>> swire_slave_assertions.sv
// Port checker for the single-wire slave command port
`timescale 1ns/10ps
module swire_slave_assertions #(
  parameter int unsigned COPY_CYC = swire_pkg::COPY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe,
  input wire logic eeprom_copy_busy_flag,
  input wire logic block0_locked_flag,
  input wire logic block1_locked_flag
);
  logic [15:0] lo_cnt_r;
  logic [15:0] oe_cnt_r;
  logic [15:0] busy_cnt_r;
  logic mapped;
  assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C};
  // Run lengths: line low, device drive, copy busy
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_cnt_r <= 16'h0000;
      oe_cnt_r <= 16'h0000;
      busy_cnt_r <= 16'h0000;
    end
    else
    begin
      lo_cnt_r <= dq_in ? 16'h0000 : lo_cnt_r + 16'h0001;
      oe_cnt_r <= dq_oe ? oe_cnt_r + 16'h0001 : 16'h0000;
      busy_cnt_r <= eeprom_copy_busy_flag ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access_start;
    psel && penable && !pready && !$past(penable);
  endsequence
  // Threshold above the presence pulse length, so presence never counts as reset
  sequence s_line_reset_end;
    $rose(dq_in) && lo_cnt_r >= 16'h04E2;
  endsequence
  a_ready_second: assert property (s_access_start |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property (s_access_start ##0 !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_read_no_err: assert property (s_access_start ##0 mapped && !pwrite |=> !pslverr)
    else $error("mapped read refused");
  a_open_drain: assert property (dq_oe |-> dq_out == 1'b0 && !dq_in)
    else $error("line driven high");
  a_quiet_line_reset: assert property (lo_cnt_r > 16'h04E2 |-> !dq_oe)
    else $error("drive during line reset");
  a_presence_wait: assert property (s_line_reset_end |-> ##[295:310] $rose(dq_oe))
    else $error("presence delay wrong");
  a_drive_length: assert property ($fell(dq_oe) |->
    oe_cnt_r inside {[16'h0122:16'h0136], [16'h04A6:16'h04BA]})
    else $error("drive length wrong");
  a_copy_length: assert property ($fell(eeprom_copy_busy_flag) |->
    busy_cnt_r >= COPY_CYC - 1 && busy_cnt_r <= COPY_CYC + 1)
    else $error("copy busy length wrong");
  a_lock_kept: assert property (!$fell(block0_locked_flag) && !$fell(block1_locked_flag))
    else $error("lock flag cleared");
endmodule // swire_slave_assertions

bind swire_slave swire_slave_assertions #(.COPY_CYC(COPY_CYC)) swire_slave_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .eeprom_copy_busy_flag(eeprom_copy_busy_flag), .block0_locked_flag(block0_locked_flag),
  .block1_locked_flag(block1_locked_flag)
);

// >>> swire_master_model.sv
// Behavioural single-wire bus master with the line pull-up
`timescale 1ns/10ps
module swire_master_model (
  input wire logic pclk,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic line
);
  localparam int SLOT = 600;
  localparam int REC = 10;
  logic drv_low_r = 1'b0;
  // Pull-up wins unless a party pulls low
  assign line = !(drv_low_r || (dev_oe && !dev_out));
  // Fall opens each 60us slot, then 1us recovery
  task automatic slot(input int low, input int smp, output logic b);
    @(posedge pclk);
    drv_low_r <= 1'b1;
    repeat (low) @(posedge pclk);
    drv_low_r <= 1'b0;
    repeat (smp - low) @(posedge pclk);
    b = line;
    repeat (SLOT + REC - smp) @(posedge pclk);
  endtask
  task automatic send_byte(input logic [7:0] v);
    logic b;
    for (int i = 0; i < 8; i++)
    begin
      slot(v[i] ? 10 : SLOT, SLOT, b); // One released at 1us, zero held
    end
  endtask
  task automatic get_bits(input int n, output logic [7:0] v);
    logic b;
    v = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      slot(10, 150, b); // Low 1us, sample at 15us
      v[i] = b;
    end
  endtask
  // Long low ends any transfer, then presence is timed
  task automatic line_reset(output int wait_cyc, output int low_cyc);
    wait_cyc = 0;
    low_cyc = 0;
    @(posedge pclk);
    drv_low_r <= 1'b1;
    repeat (1300) @(posedge pclk);
    drv_low_r <= 1'b0;
    @(posedge pclk);
    while (line === 1'b1 && wait_cyc < 600)
    begin
      @(posedge pclk);
      wait_cyc++;
    end
    while (line === 1'b0 && low_cyc < 2000)
    begin
      @(posedge pclk);
      low_cyc++;
    end
    repeat (REC) @(posedge pclk);
  endtask
endmodule // swire_master_model

// >>> test_single_wire_slave_command_port.sv
// Self-checking bench for the single-wire slave command port
`timescale 1ns/10ps
module test_single_wire_slave_command_port;
  localparam int unsigned COPY_CYC = 50; // Short copy keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line;
  logic dq_out;
  logic dq_oe;
  logic busy;
  logic chg;
  logic dis;
  logic lk0;
  logic lk1;
  int fails = 0;
  int n_compared = 0;
  always #50 pclk = ~pclk;
  swire_slave #(.COPY_CYC(COPY_CYC)) swire_slave_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_in(line), .dq_out(dq_out),
    .dq_oe(dq_oe), .charge_switch_output(chg), .discharge_switch_output(dis), .eeprom_copy_busy_flag(busy),
    .block0_locked_flag(lk0), .block1_locked_flag(lk1)
  );
  swire_master_model swire_master_model_i (.pclk(pclk), .dev_oe(dq_oe), .dev_out(dq_out), .line(line));
  task automatic stop_test();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
    begin
      $display("Result: passed");
    end
    else
    begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waits for pready; only the watchdog ends a hung access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] v);
    swire_master_model_i.send_byte(v);
  endtask
  task automatic rx(input int n, output logic [7:0] v);
    swire_master_model_i.get_bits(n, v);
  endtask
  task automatic start_frame();
    int w;
    int l;
    swire_master_model_i.line_reset(w, l);
    check({31'h0, w >= 295 && w <= 310}, 32'h0000_0001);
    check({31'h0, l >= 1190 && l <= 1210}, 32'h0000_0001);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] a);
    start_frame();
    tx(swire_pkg::OP_SKIP_NET);
    tx(op);
    tx(a);
  endtask
  task automatic test_apb();
    logic [31:0] q;
    logic e;
    check({28'h0000000, chg, dis, lk1, lk0}, 32'h0000_000C);
    apb(1'b0, swire_pkg::APB_STATUS, 32'h0000_0000, q, e);
    check(q, 32'h0000_0061);
    apb(1'b0, swire_pkg::APB_NET_LO, 32'h0000_0000, q, e);
    check(q, swire_pkg::NET_ADDR_RESET[31:0]);
    apb(1'b1, swire_pkg::APB_CTRL, 32'h0000_0002, q, e);
    apb(1'b0, swire_pkg::APB_CTRL, 32'h0000_0000, q, e);
    check(q, 32'h0000_0002);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, q, e);
    check({31'h0, e}, 32'h0000_0001);
    apb(1'b1, swire_pkg::APB_CTRL, 32'h0000_0000, q, e);
  endtask
  task automatic test_write_read();
    logic [7:0] b;
    cmd(swire_pkg::OP_WRITE_DATA, 8'h21);
    tx(8'hA5);
    cmd(swire_pkg::OP_READ_DATA, 8'h21);
    rx(8, b);
    check({24'h000000, b}, 32'h0000_00A5);
  endtask
  // Each read is cut after four bits by a line reset
  task automatic test_read_net();
    logic [7:0] b;
    logic [31:0] q;
    logic e;
    start_frame();
    tx(swire_pkg::OP_READ_NET_0);
    rx(4, b);
    check({24'h000000, b}, {28'h0000000, swire_pkg::NET_ADDR_RESET[3:0]});
    apb(1'b1, swire_pkg::APB_CTRL, 32'h0000_0001, q, e);
    start_frame();
    tx(swire_pkg::OP_READ_NET_1);
    rx(4, b);
    check({24'h000000, b}, {28'h0000000, swire_pkg::NET_ADDR_RESET[3:0]});
    apb(1'b1, swire_pkg::APB_CTRL, 32'h0000_0000, q, e);
  endtask
  task automatic test_copy();
    logic [31:0] q;
    logic e;
    int n;
    n = 0;
    cmd(swire_pkg::OP_COPY, 8'h20);
    check({31'h0, busy}, 32'h0000_0001);
    apb(1'b0, swire_pkg::APB_STATUS, 32'h0000_0000, q, e);
    check({31'h0, q[4]}, 32'h0000_0001);
    while (busy === 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, busy}, 32'h0000_0000);
    check({30'h0, lk1, lk0}, 32'h0000_0000);
  endtask
  task automatic test_read_top();
    logic [7:0] b;
    cmd(swire_pkg::OP_READ_DATA, 8'hFF);
    rx(8, b);
    check({24'h000000, b}, 32'h0000_0000);
    rx(4, b);
    check({24'h000000, b}, 32'h0000_000F);
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    test_apb();
    test_write_read();
    test_read_net();
    test_copy();
    test_read_top();
    stop_test();
  end
  initial
  begin
    repeat (150000) @(posedge pclk);
    fails++;
    stop_test();
  end
endmodule // test_single_wire_slave_command_port
